// [design/scp_prescaler.sv]
// Added by the designer: register access over APB and the address map.
`timescale 1ns/100ps
`default_nettype none
module scp_prescaler (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [1:0] unit_clock_enable,
  output logic [1:0] operation_clock_a,
  output logic [1:0] operation_clock_b
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode.

  // Writes act in the access phase; the slave always answers at once.
  logic wr;
  logic rd_setup;
  logic known;
  assign wr = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  always_comb begin
    case (paddr)
      scp_pkg::scp_gate_off, scp_pkg::scp_sel0_off, scp_pkg::scp_sel1_off,
      scp_pkg::scp_sel0l_off, scp_pkg::scp_sel1l_off,
      scp_pkg::scp_bitset_off, scp_pkg::scp_bitclr_off: known = 1'b1;
      default: known = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Peripheral clock gate register.

  logic [7:0] peripheral_clock_gate;
  logic [7:0] bit_mask;
  assign bit_mask = 8'h01 << pwdata[2:0];
  // Byte write replaces it; bit set/clear ports emulate one-bit writes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peripheral_clock_gate <= scp_pkg::scp_gate_reset; // [R5]
    end else if (wr && pstrb[0]) begin
      if (paddr == scp_pkg::scp_gate_off) begin
        peripheral_clock_gate <= pwdata[7:0]; // [R4]
      end else if (paddr == scp_pkg::scp_bitset_off) begin
        peripheral_clock_gate <= peripheral_clock_gate | bit_mask; // [R4]
      end else if (paddr == scp_pkg::scp_bitclr_off) begin
        peripheral_clock_gate <= peripheral_clock_gate & ~bit_mask; // [R4]
      end
    end
  end

  logic [1:0] gate;
  assign gate = {peripheral_clock_gate[scp_pkg::scp_gate_bit1], // [R2]
                 peripheral_clock_gate[scp_pkg::scp_gate_bit0]}; // [R1]

  ////////////////////////////////////////////////////////////////////////////
  // Per-unit select register and dividers.

  scp_pkg::scp_sel_t sel [scp_pkg::scp_units];
  logic [scp_pkg::scp_div_w-1:0] div [scp_pkg::scp_units];

  genvar u;
  generate
    for (u = 0; u < scp_pkg::scp_units; u++) begin : g_unit
      logic [11:0] word_off;
      logic [11:0] byte_off;
      assign word_off = (u == 0) ? scp_pkg::scp_sel0_off
                                 : scp_pkg::scp_sel1_off;
      assign byte_off = (u == 0) ? scp_pkg::scp_sel0l_off
                                 : scp_pkg::scp_sel1l_off;

      // Select register; upper byte has no storage and reads zero.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sel[u] <= scp_pkg::scp_sel_reset[7:0]; // [R13]
        end else if (!gate[u]) begin
          sel[u] <= scp_pkg::scp_sel_reset[7:0]; // [R6]
        end else if (wr && pstrb[0] &&
                     (paddr == word_off || paddr == byte_off)) begin
          sel[u] <= pwdata[7:0]; // [R8] [R11] [R12] [R15]
        end
      end

      // Free-running divider; a stopped gate clears it to zero to save power.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          div[u] <= '0;
        end else if (!gate[u]) begin
          div[u] <= '0; // [R3]
        end else begin
          div[u] <= div[u] + 1'b1;
        end
      end

      // One-cycle enable pulse each 2^k clocks; k=0 is every cycle.
      function automatic logic tick(input logic [3:0] k,
                                    input logic [14:0] cnt);
        logic [15:0] m;
        m = (16'h0001 << k) - 16'h0001;
        tick = ((cnt & m[14:0]) == m[14:0]);
      endfunction

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          unit_clock_enable[u] <= 1'b0;
          operation_clock_a[u] <= 1'b0;
          operation_clock_b[u] <= 1'b0;
        end else begin
          unit_clock_enable[u] <= gate[u]; // [R3]
          operation_clock_a[u] <= gate[u] && tick(sel[u].sel_a, div[u]); // [R9]
          operation_clock_b[u] <= gate[u] && tick(sel[u].sel_b, div[u]); // [R9]
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Read data and response, registered in the setup cycle.

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (rd_setup) begin
      case (paddr)
        scp_pkg::scp_gate_off: prdata <= {24'h000000, peripheral_clock_gate};
        scp_pkg::scp_sel0_off, scp_pkg::scp_sel0l_off:
          prdata <= {24'h000000, sel[0]}; // [R15]
        scp_pkg::scp_sel1_off, scp_pkg::scp_sel1l_off:
          prdata <= {24'h000000, sel[1]};
        default: prdata <= '0;
      endcase
    end
  end

  // Unmapped addresses get an error response in the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~known;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  // Register reads: a setup cycle, then the access cycle that answers it.
  sequence s_gate_read;
    rd_setup && paddr == scp_pkg::scp_gate_off ##1 pready;
  endsequence

  sequence s_sel0_read;
    rd_setup && paddr == scp_pkg::scp_sel0_off ##1 pready;
  endsequence

  sequence s_sel1_read;
    rd_setup && paddr == scp_pkg::scp_sel1_off ##1 pready;
  endsequence

  // A gated-off unit 0 shows no enable and no operation clock a.
  a_gate_off_quiet: assert property ( // [R3]
    @(posedge pclk) disable iff (!presetn)
    !gate[0] |=> !operation_clock_a[0] && !unit_clock_enable[0])
    else $error("unit 0 clocked while gated");

  // The second clock of unit 0 also stops with its gate.
  a_gate_off_b0: assert property ( // [R3]
    @(posedge pclk) disable iff (!presetn)
    !gate[0] |=> !operation_clock_b[0])
    else $error("unit 0 clock b running while gated");

  // Unit 1 goes fully quiet when its gate bit is cleared.
  a_gate_off_quiet1: assert property ( // [R3]
    @(posedge pclk) disable iff (!presetn)
    !gate[1] |=> !operation_clock_a[1] && !operation_clock_b[1] &&
                 !unit_clock_enable[1])
    else $error("unit 1 clocked while gated");

  // A gated divider is parked at zero, so it draws no switching power.
  a_gated_div_zero: assert property ( // [R3]
    @(posedge pclk) disable iff (!presetn)
    !gate[1] |=> div[1] == '0)
    else $error("gated divider still counting");

  // A byte write replaces the whole gate register.
  a_gate_byte_write: assert property ( // [R4]
    @(posedge pclk) disable iff (!presetn)
    wr && pstrb[0] && paddr == scp_pkg::scp_gate_off
    |=> peripheral_clock_gate == $past(pwdata[7:0]))
    else $error("gate byte write lost");

  // The bit-set port touches exactly one gate bit.
  a_bitset_sets: assert property ( // [R4]
    @(posedge pclk) disable iff (!presetn)
    wr && pstrb[0] && paddr == scp_pkg::scp_bitset_off
    |=> peripheral_clock_gate ==
        ($past(peripheral_clock_gate) | $past(bit_mask)))
    else $error("gate bit set wrong");

  // The bit-clear port touches exactly one gate bit.
  a_bitclr_clears: assert property ( // [R4]
    @(posedge pclk) disable iff (!presetn)
    wr && pstrb[0] && paddr == scp_pkg::scp_bitclr_off
    |=> peripheral_clock_gate ==
        ($past(peripheral_clock_gate) & ~$past(bit_mask)))
    else $error("gate bit clear wrong");

  // Without the low byte lane a write must leave the gate alone.
  a_gate_no_strobe: assert property ( // [R4]
    @(posedge pclk) disable iff (!presetn)
    wr && !pstrb[0] |=> $stable(peripheral_clock_gate))
    else $error("gate written without strobe");

  // Reading the gate returns the value it held in the setup cycle.
  a_gate_read_value: assert property ( // [R4]
    @(posedge pclk) disable iff (!presetn)
    s_gate_read |-> prdata == {24'h000000, $past(peripheral_clock_gate)})
    else $error("gate read value wrong");

  // Reset leaves every gate bit clear; checked during reset itself.
  a_reset_gate_zero: assert property ( // [R5]
    @(posedge pclk)
    !presetn |-> peripheral_clock_gate == scp_pkg::scp_gate_reset)
    else $error("gate not cleared by reset");

  // With the gate cleared by reset no unit is enabled.
  a_reset_enable_off: assert property ( // [R5]
    @(posedge pclk)
    !presetn |-> unit_clock_enable == 2'b00)
    else $error("unit enabled during reset");

  // Reset clears both select registers.
  a_reset_sel_zero: assert property ( // [R13]
    @(posedge pclk)
    !presetn |-> sel[0] == 8'h00 && sel[1] == 8'h00)
    else $error("select not cleared by reset");

  // A gated-off unit holds its select at the default value.
  a_gated_sel_zero: assert property ( // [R6]
    @(posedge pclk) disable iff (!presetn)
    !gate[1] |=> sel[1] == 8'h00)
    else $error("gated select not cleared");

  // Same for unit 0, whose select is written while still gated.
  a_gated_sel0_zero: assert property ( // [R6]
    @(posedge pclk) disable iff (!presetn)
    !gate[0] |=> sel[0] == 8'h00)
    else $error("gated select 0 not cleared");

  // Selector zero gives a pulse on every cycle.
  a_sel_undiv_clock: assert property ( // [R9]
    @(posedge pclk) disable iff (!presetn)
    gate[0] && sel[0].sel_a == 4'h0 |=> operation_clock_a[0])
    else $error("undivided clock missing");

  // Unit 1 clock a, undivided.
  a_undiv_a1: assert property ( // [R9]
    @(posedge pclk) disable iff (!presetn)
    gate[1] && sel[1].sel_a == 4'h0 |=> operation_clock_a[1])
    else $error("unit 1 undivided clock a missing");

  // Unit 1 clock b, undivided.
  a_undiv_b1: assert property ( // [R9]
    @(posedge pclk) disable iff (!presetn)
    gate[1] && sel[1].sel_b == 4'h0 |=> operation_clock_b[1])
    else $error("unit 1 undivided clock b missing");

  // Divide by two never gives two pulses in a row.
  a_sel_div_two: assert property ( // [R9]
    @(posedge pclk) disable iff (!presetn)
    operation_clock_b[0] && $past(sel[0].sel_b) == 4'h1 && $stable(sel[0])
    |=> !operation_clock_b[0])
    else $error("divide by two wrong");

  // Divide by 2^11 pulses only when the low eleven counter bits are set.
  a_sel_div_2k: assert property ( // [R9]
    @(posedge pclk) disable iff (!presetn)
    gate[0] && sel[0].sel_a == 4'hb && div[0][10:0] != 11'h7ff
    |=> !operation_clock_a[0])
    else $error("divide by 2048 pulsed early");

  // A running divider advances by one each cycle.
  a_div_counts: assert property ( // [R9]
    @(posedge pclk) disable iff (!presetn)
    gate[0] |=> div[0] == 15'($past(div[0]) + 15'h0001))
    else $error("divider skipped a count");

  // Unit 0 enable follows its gate bit one cycle later.
  a_gate_bit0_map: assert property ( // [R1]
    @(posedge pclk) disable iff (!presetn)
    ##1 unit_clock_enable[0] ==
        $past(peripheral_clock_gate[scp_pkg::scp_gate_bit0]))
    else $error("unit 0 gate bit mismatch");

  // Unit 1 enable follows its gate bit one cycle later.
  a_gate_bit1_map: assert property ( // [R2]
    @(posedge pclk) disable iff (!presetn)
    ##1 unit_clock_enable[1] ==
        $past(peripheral_clock_gate[scp_pkg::scp_gate_bit1]))
    else $error("unit 1 gate bit mismatch");

  // The low-byte alias of unit 0 writes the same storage.
  a_sel_low_alias: assert property ( // [R12]
    @(posedge pclk) disable iff (!presetn)
    wr && pstrb[0] && gate[0] && paddr == scp_pkg::scp_sel0l_off
    |=> sel[0] == $past(pwdata[7:0]))
    else $error("alias write lost");

  // The low-byte alias of unit 1 writes the same storage.
  a_sel1_low_alias: assert property ( // [R12]
    @(posedge pclk) disable iff (!presetn)
    wr && pstrb[0] && gate[1] && paddr == scp_pkg::scp_sel1l_off
    |=> sel[1] == $past(pwdata[7:0]))
    else $error("unit 1 alias write lost");

  // Upper select bits always read back as zero.
  a_sel_upper_zero: assert property ( // [R15]
    @(posedge pclk) disable iff (!presetn)
    pready && !pwrite && paddr == scp_pkg::scp_sel1_off
    |-> prdata[31:8] == 24'h000000)
    else $error("upper select bits nonzero");

  // Unit 0 select reads back both fields in place.
  a_sel0_read_value: assert property ( // [R8] [R15]
    @(posedge pclk) disable iff (!presetn)
    s_sel0_read |-> prdata == {24'h000000, $past(sel[0])})
    else $error("select 0 read value wrong");

  // Unit 1 select reads back both fields in place.
  a_sel1_read_value: assert property ( // [R8] [R15]
    @(posedge pclk) disable iff (!presetn)
    s_sel1_read |-> prdata == {24'h000000, $past(sel[1])})
    else $error("select 1 read value wrong");

  // A word write to unit 0 lands in both fields.
  a_sel0_word_write: assert property ( // [R8] [R11]
    @(posedge pclk) disable iff (!presetn)
    wr && pstrb[0] && gate[0] && paddr == scp_pkg::scp_sel0_off
    |=> sel[0] == $past(pwdata[7:0]))
    else $error("select 0 word write lost");

  // A word write to unit 1 lands in both fields.
  a_sel_word_write: assert property ( // [R8] [R11]
    @(posedge pclk) disable iff (!presetn)
    wr && pstrb[0] && gate[1] && paddr == scp_pkg::scp_sel1_off
    |=> sel[1] == $past(pwdata[7:0]))
    else $error("select word write lost");

  // Every setup cycle is answered in the very next cycle.
  a_ready_after_setup: assert property ( // [R11]
    @(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready)
    else $error("no ready after setup");

  // Ready is a single pulse per transfer.
  a_ready_single: assert property ( // [R11]
    @(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held too long");

  // Unmapped addresses are answered with an error.
  a_bad_addr_err: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && !penable && !known |=> pready && pslverr)
    else $error("unmapped address not flagged");

  // Mapped addresses never see an error.
  a_good_addr_ok: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && !penable && known |=> !pslverr)
    else $error("mapped address flagged");

endmodule // scp_prescaler
`default_nettype wire

// [design/scp_pkg.sv]
// Functional notes
// R1: Gate bit for unit 0 at bit 2.
// R2: Gate bit for unit 1 at bit 3.
// R3: Gate bit zero stops that unit's clock.
// R4: Gate register takes bit and byte writes.
// R5: Gate register resets to all zeros.
// R6: Gated-off unit holds defaults, ignores writes.
// R7: Software writes zero to unimplemented gate bits.
// R8: Select bits 7:4 clock b, 3:0 clock a.
// R9: Selector k divides the clock by 2^k.
// R10: No select rewrite while a channel runs.
// R11: Select register accepts 16-bit writes.
// R12: Low byte writable through a byte alias.
// R13: Select register resets to zero.
// R14: Stop channels before changing the clock source.
// R15: Select bits 15:8 read zero, ignore writes.
`default_nettype none
package scp_pkg;
  localparam int scp_units = 2;
  localparam logic [11:0] scp_gate_off = 12'h000;
  localparam logic [11:0] scp_sel0_off = 12'h004;
  localparam logic [11:0] scp_sel1_off = 12'h008;
  localparam logic [11:0] scp_sel0l_off = 12'h00c;
  localparam logic [11:0] scp_sel1l_off = 12'h010;
  localparam logic [11:0] scp_bitset_off = 12'h014;
  localparam logic [11:0] scp_bitclr_off = 12'h018;
  localparam logic [7:0] scp_gate_reset = 8'h00;
  localparam logic [15:0] scp_sel_reset = 16'h0000;
  localparam int scp_gate_bit0 = 2;
  localparam int scp_gate_bit1 = 3;
  localparam int scp_sel_a_lsb = 0;
  localparam int scp_sel_b_lsb = 4;
  localparam int scp_sel_w = 4;
  localparam int scp_div_w = 15;
  typedef struct packed {
    logic [3:0] sel_b;
    logic [3:0] sel_a;
  } scp_sel_t;
endpackage
`default_nettype wire

// [bench/scp_prescaler_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module scp_prescaler_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [1:0] unit_clock_enable, operation_clock_a, operation_clock_b;
  logic [15:0] lfsr;
  int err_count, tests_run, m_gate, m_sel[2], na, nb;
  scp_prescaler dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .unit_clock_enable(unit_clock_enable),
    .operation_clock_a(operation_clock_a),
    .operation_clock_b(operation_clock_b));
////////////////////////////////////////////////////////////////////////////
  // Free-running bus clock; its source never changes mid-run.
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // Shift-register source of random select values.
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic finish_test();
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
      input string m);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic chk_cnt(input int got, input int exp);
    tests_run++;
    if (got != exp) begin
      err_count++;
      $display("MISMATCH %0t pulse count %0d exp %0d", $time, got, exp);
    end
  endtask
  // One transfer; an idle edge first so psel is never assigned twice.
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      finish_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Writes a register and mirrors the effect in the reference model.
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    if (pstrb[0]) begin
      case (a)
        scp_pkg::scp_gate_off: m_gate = d[7:0];
        scp_pkg::scp_bitset_off: m_gate |= 1 << d[2:0];
        scp_pkg::scp_bitclr_off: m_gate &= ~(1 << d[2:0]);
        scp_pkg::scp_sel0_off, scp_pkg::scp_sel0l_off: m_sel[0] = d[7:0];
        scp_pkg::scp_sel1_off, scp_pkg::scp_sel1l_off: m_sel[1] = d[7:0];
        default: ;
      endcase
    end
    for (int u = 0; u < 2; u++)
      if (!m_gate[scp_pkg::scp_gate_bit0 + u]) m_sel[u] = 0;
  endtask
  task automatic rdchk(input logic [11:0] a, input int e);
    apb(1'b0, a, 32'h0);
    chk(rd, 32'(e), "read data");
    chk(32'(er), 32'h0, "error flag");
  endtask
  // Counts enable pulses of one unit over a whole number of periods.
  task automatic count(input int u, input int w);
    na = 0;
    nb = 0;
    repeat (w) begin
      @(posedge pclk);
      // An unknown pulse spoils the count so that it cannot pass.
      na += (operation_clock_a[u] === 1'b1) ? 1 : 0;
      nb += (operation_clock_b[u] === 1'b1) ? 1 : 0;
      if ($isunknown({operation_clock_a[u], operation_clock_b[u]}))
        na += 4096;
    end
  endtask
////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'h1;
    m_gate = 0;
    m_sel = '{0, 0};
    lfsr = 16'h005e;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(scp_pkg::scp_gate_off, 0);
    rdchk(scp_pkg::scp_sel0_off, 0);
    wr(scp_pkg::scp_sel0_off, 32'h55);
    rdchk(scp_pkg::scp_sel0_off, m_sel[0]);
    chk(32'(unit_clock_enable), 32'h0, "enable");
    wr(scp_pkg::scp_gate_off, 32'h0c);
    repeat (2) @(posedge pclk);
    chk(32'(unit_clock_enable), 32'h3, "enable");
    rdchk(scp_pkg::scp_gate_off, m_gate);
    for (int i = 0; i < 12; i++) begin
      lfsr = nxt(lfsr);
      wr(scp_pkg::scp_sel0_off, {lfsr[15:8], 4'(11 - i), 4'(i)});
      rdchk(scp_pkg::scp_sel0_off, m_sel[0]);
      repeat (4) @(posedge pclk);
      count(0, 2048);
      chk_cnt(na, 2048 >> i);
      chk_cnt(nb, 2048 >> (11 - i));
    end
    wr(scp_pkg::scp_sel1l_off, {24'h0, lfsr[7:0]});
    rdchk(scp_pkg::scp_sel1_off, m_sel[1]);
    wr(scp_pkg::scp_bitclr_off, 32'h3);
    repeat (2) @(posedge pclk);
    chk(32'(unit_clock_enable), 32'h1, "enable");
    rdchk(scp_pkg::scp_sel1_off, m_sel[1]);
    count(1, 64);
    chk_cnt(na + nb, 0);
    wr(scp_pkg::scp_bitset_off, 32'h3);
    rdchk(scp_pkg::scp_gate_off, m_gate);
    pstrb <= 4'h0;
    wr(scp_pkg::scp_gate_off, 32'h0);
    pstrb <= 4'h1;
    rdchk(scp_pkg::scp_gate_off, m_gate);
    apb(1'b0, 12'h020, 32'h0);
    chk(32'(er), 32'h1, "error flag");
    finish_test();
  end
endmodule // scp_prescaler_tb
`default_nettype wire
